// file: hdl/alr_map.vh
`ifndef ALR_MAP_VH
`define ALR_MAP_VH
// Register indexes
`define ALR_REG_CFG       4'h0
`define ALR_REG_EVT       4'h1
`define ALR_REG_SCUR      4'h2
`define ALR_REG_SHYS      4'h3
`define ALR_REG_LBTIME    4'h4
`define ALR_REG_LBLEVEL   4'h5
`define ALR_REG_LBBAND    4'h6
`define ALR_REG_A1TYPE    4'h7
`define ALR_REG_COUT      4'h8
`define ALR_REG_AUX01     4'h9
`define ALR_REG_AUX23     4'hA
`define ALR_REG_LEVEL     4'hB
`define ALR_REG_STATUS    4'hC
// Configuration bits
`define ALR_CFG_LATCH     0
`define ALR_CFG_SUSE      1
`define ALR_CFG_HCOOL     2
`define ALR_CFG_STD       3
`define ALR_CFG_LOGIC     4
`define ALR_CFG_PATTERN   5
`define ALR_CFG_SINGLE    6
`define ALR_CFG_A1ASSIGN  7
`define ALR_CFG_RELAY1    8
`define ALR_CFG_RELAY2    9
`define ALR_CFG_CAUX_LO   10
`define ALR_CFG_CAUX_HI   11
`define ALR_CFG_FKCANCEL  12
// Reset values
`define ALR_CFG_RST       16'h038A
`define ALR_EVT_RST       6'h00
`define ALR_SCUR_RST      10'h032
`define ALR_SCUR_MAX      10'h1F4
`define ALR_SHYS_RST      10'h001
`define ALR_SHYS_MIN      10'h001
`define ALR_LBTIME_RST    14'h0000
`define ALR_LBLEVEL_RST   14'h0050
`define ALR_LBBAND_RST    14'h001E
`define ALR_A1TYPE_RST    5'h00
`define ALR_A1TYPE_LOOP   5'h0C
`define ALR_LEVEL_RST     3'h0
// Setting levels
`define ALR_LVL_INITIAL   3'h1
`define ALR_LVL_COMMS     3'h2
`define ALR_LVL_ADVANCED  3'h3
`define ALR_LVL_CALIB     3'h4
// Output source codes
`define ALR_SRC_NONE      5'h00
`define ALR_SRC_HEAT      5'h01
`define ALR_SRC_COOL      5'h02
`define ALR_SRC_ALARM1    5'h03
`define ALR_SRC_ALARM2    5'h04
`define ALR_SRC_ALARM3    5'h05
`define ALR_SRC_ALARM4    5'h06
`define ALR_SRC_HEATER    5'h07
`define ALR_SRC_WORK1     5'h0F
`define ALR_SRC_WORK8     5'h16
`define ALR_SRC_LAST      5'h1B
// Timing
`define ALR_CLK_HZ        50000000
`define ALR_DETECT_UNIT_S 1
`endif

// file: hdl/alr_output_router.v
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
// Summary of operation
// RULE1 - Latch keeps short alarm until cleared
// RULE2 - Maximum short current setting releases latch
// RULE3 - Function key cancel releases latch
// RULE4 - Assigned event input releases latch
// RULE5 - Reset clears latched short alarm
// RULE6 - Setting levels force latched output off
// RULE7 - Short alarm hysteresis 0.1 to 50.0 A
// RULE8 - Hysteresis only when used, unlatched
// RULE9 - Zero interval disables loop burnout detection
// RULE10 - Detection needs standard model, alarm1 type 12
// RULE11 - Deviation above level flags loop burnout
// RULE12 - Unreduced deviation beyond band flags burnout
// RULE13 - Each control output takes one source
// RULE14 - Cooling under standard control outputs 0%
// RULE15 - Status sources only on relay outputs; checked on write only, kept if the relay bit is cleared later
// RULE16 - Program end inactive when pattern off
// RULE17 - Heating/cooling switches assignment to cooling
// RULE18 - Auxiliary outputs routed, model defaults
// RULE19 - Single output uses auxiliary as cooling
// RULE20 - Work bits only with logic operation; checked on write only, kept if logic is cleared later
`include "alr_map.vh"

module alr_output_router #(
  parameter TICKS_PER_UNIT = `ALR_CLK_HZ * `ALR_DETECT_UNIT_S
) (
  input  wire        clock,
  input  wire        rst_n,
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [15:0] reg_rdata,
  input  wire        heater_detect_fitted,
  input  wire [9:0]  heater_current,
  input  wire [5:0]  event_in,
  input  wire        function_key,
  input  wire [15:0] set_point,
  input  wire [15:0] process_value,
  input  wire        heat_ctrl,
  input  wire        cool_ctrl,
  input  wire [3:0]  alarm_in,
  input  wire        heater_burnout,
  input  wire        input_error,
  input  wire        remote_setpoint_fault,
  input  wire        program_end,
  input  wire        run_state,
  input  wire        integrated_alarm,
  input  wire [7:0]  work_bits,
  output reg  [1:0]  ctrl_out,
  output reg  [3:0]  aux_out,
  output reg         short_alarm,
  output reg         loop_burnout
);

  reg  [15:0] cfg;
  reg  [5:0]  evt_cancel;
  reg  [9:0]  short_cur;
  reg  [9:0]  short_hys;
  reg  [13:0] lb_time;
  reg  [13:0] lb_level;
  reg  [13:0] lb_band;
  reg  [4:0]  a1_type;
  reg  [4:0]  cout_sel [0:1];
  reg  [4:0]  aux_sel [0:3];
  reg  [2:0]  level;
  reg  [6:0]  pin_s1;
  reg  [6:0]  pin_s2;
  reg  [6:0]  pin_prev;
  reg         short_state;
  reg  [31:0] unit_cnt;
  reg  [13:0] lb_cnt;
  reg  [16:0] start_dev;
  reg         prev_over;
  wire [16:0] dev;
  wire [16:0] sp_ext;
  wire [16:0] pv_ext;
  wire [16:0] diff;
  wire        in_setup;
  wire        raw_short;
  wire        hold_short;
  wire [9:0]  release_lvl;
  wire        cancel;
  wire        lb_enable;
  wire        unit_tick;
  wire        over;
  wire        reduced;
  wire        hc_rise;
  wire [2:0]  cool_aux;
  wire [22:0] src;
  wire        alarm1_src;
  reg         next_short;
  integer     i;

  // Source allowed for this output
  function alr_allowed;
    input [4:0] code;
    input       relay;
    input       is_aux;
    input       logic_on;
    begin
      alr_allowed = 1'b1;
      if (code > `ALR_SRC_LAST) begin
        alr_allowed = 1'b0;
      end
      if (is_aux && code > `ALR_SRC_WORK8) begin
        alr_allowed = 1'b0;
      end
      // RULE15 relay only sources
      if (!relay && code >= `ALR_SRC_ALARM1 && code <= `ALR_SRC_WORK8) begin
        alr_allowed = 1'b0;
      end
      // RULE20 work bits hidden
      if (!logic_on && code >= `ALR_SRC_WORK1 && code <= `ALR_SRC_WORK8) begin
        alr_allowed = 1'b0;
      end
    end
  endfunction

  // Picks one source bit
  function alr_route;
    input [4:0]  code;
    input [22:0] vec;
    begin
      if (code <= `ALR_SRC_WORK8) begin
        alr_route = vec[code];
      end else begin
        alr_route = 1'b0;
      end
    end
  endfunction

  assign in_setup = (level == `ALR_LVL_INITIAL) || (level == `ALR_LVL_COMMS) ||
                    (level == `ALR_LVL_ADVANCED) || (level == `ALR_LVL_CALIB);
  assign cool_aux = {1'b0, cfg[`ALR_CFG_CAUX_HI:`ALR_CFG_CAUX_LO]};

  // Pin synchronisers
  always @(posedge clock) begin
    if (!rst_n) begin
      pin_s1   <= 7'h00;
      pin_s2   <= 7'h00;
      pin_prev <= 7'h00;
    end else begin
      pin_s1   <= {function_key, event_in};
      pin_s2   <= pin_s1;
      pin_prev <= pin_s2;
    end
  end

  // RULE2 maximum current cancel
  // RULE3 function key cancel
  // RULE4 event input cancel
  assign cancel = (short_cur == `ALR_SCUR_MAX) ||
                  (cfg[`ALR_CFG_FKCANCEL] && pin_s2[6] && !pin_prev[6]) ||
                  (|(evt_cancel & pin_s2[5:0] & ~pin_prev[5:0]));

  assign raw_short   = heater_current >= short_cur;
  // RULE7 hysteresis release point
  assign release_lvl = (short_cur > short_hys) ? (short_cur - short_hys) : 10'h000;
  assign hold_short  = heater_current >= release_lvl;

  always @* begin
    next_short = 1'b0;
    if (!cfg[`ALR_CFG_SUSE] || in_setup) begin
      next_short = 1'b0;
    end else if (cfg[`ALR_CFG_LATCH]) begin
      // RULE1 hold until cancel
      next_short = raw_short | (short_state & ~cancel);
    end else begin
      // RULE8 hysteresis when unlatched
      next_short = raw_short | (short_state & hold_short);
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      // RULE5 reset clears latch
      short_state <= 1'b0;
      short_alarm <= 1'b0;
    end else begin
      short_state <= next_short;
      // RULE6 setup levels force off
      short_alarm <= next_short & ~in_setup;
    end
  end

  // RULE10 model and alarm1 type
  // RULE9 zero interval disables
  assign lb_enable = (lb_time != 14'h0000) && cfg[`ALR_CFG_STD] &&
                     cfg[`ALR_CFG_A1ASSIGN] && (a1_type == `ALR_A1TYPE_LOOP);
  assign sp_ext    = {set_point[15], set_point};
  assign pv_ext    = {process_value[15], process_value};
  assign diff      = sp_ext - pv_ext;
  assign dev       = diff[16] ? (17'h00000 - diff) : diff;
  assign unit_tick = (unit_cnt == TICKS_PER_UNIT - 1);
  // RULE11 level exceeded
  assign over      = dev > {3'b000, lb_level};
  // RULE12 reduction by band
  assign reduced   = (start_dev > dev) && ((start_dev - dev) > {3'b000, lb_band});

  always @(posedge clock) begin
    if (!rst_n || !lb_enable) begin
      unit_cnt     <= 32'h00000000;
      lb_cnt       <= 14'h0000;
      start_dev    <= 17'h00000;
      prev_over    <= 1'b0;
      loop_burnout <= 1'b0;
    end else begin
      unit_cnt <= unit_tick ? 32'h00000000 : unit_cnt + 32'h00000001;
      if (unit_tick) begin
        if (lb_cnt == lb_time - 14'h0001) begin
          lb_cnt    <= 14'h0000;
          start_dev <= dev;
          prev_over <= over;
          // RULE11 flag on level
          // RULE12 flag unreduced deviation
          loop_burnout <= over & ~(prev_over & reduced);
        end else begin
          lb_cnt <= lb_cnt + 14'h0001;
        end
      end
    end
  end

  assign alarm1_src = lb_enable ? loop_burnout : alarm_in[0];
  assign src[0]     = 1'b0;
  assign src[1]     = heat_ctrl;
  // RULE14 cooling 0% on standard
  assign src[2]     = cool_ctrl & cfg[`ALR_CFG_HCOOL];
  assign src[3]     = alarm1_src;
  assign src[6:4]   = alarm_in[3:1];
  assign src[7]     = heater_burnout | short_alarm;
  assign src[8]     = heater_burnout;
  assign src[9]     = short_alarm;
  assign src[10]    = input_error;
  assign src[11]    = remote_setpoint_fault;
  // RULE16 program end gated
  assign src[12]    = program_end & cfg[`ALR_CFG_PATTERN];
  assign src[13]    = run_state;
  assign src[14]    = integrated_alarm;
  assign src[22:15] = work_bits;

  assign hc_rise = reg_write && (reg_addr == `ALR_REG_CFG) &&
                   reg_wdata[`ALR_CFG_HCOOL] && !cfg[`ALR_CFG_HCOOL];

  // Register writes
  always @(posedge clock) begin
    if (!rst_n) begin
      cfg         <= `ALR_CFG_RST;
      evt_cancel  <= `ALR_EVT_RST;
      short_cur   <= `ALR_SCUR_RST;
      short_hys   <= `ALR_SHYS_RST;
      lb_time     <= `ALR_LBTIME_RST;
      lb_level    <= `ALR_LBLEVEL_RST;
      lb_band     <= `ALR_LBBAND_RST;
      a1_type     <= `ALR_A1TYPE_RST;
      level       <= `ALR_LEVEL_RST;
      cout_sel[0] <= `ALR_SRC_HEAT;
      cout_sel[1] <= `ALR_SRC_NONE;
      // RULE18 auxiliary defaults
      aux_sel[0]  <= heater_detect_fitted ? `ALR_SRC_HEATER : `ALR_SRC_ALARM1;
      aux_sel[1]  <= `ALR_SRC_ALARM2;
      aux_sel[2]  <= `ALR_SRC_ALARM3;
      aux_sel[3]  <= `ALR_SRC_ALARM4;
    end else if (reg_write) begin
      case (reg_addr)
        `ALR_REG_CFG: begin
          cfg <= reg_wdata;
          // RULE17 switch to cooling
          if (hc_rise && !reg_wdata[`ALR_CFG_SINGLE]) begin
            cout_sel[1] <= `ALR_SRC_COOL;
          end
          // RULE19 auxiliary as cooling
          if (hc_rise && reg_wdata[`ALR_CFG_SINGLE]) begin
            aux_sel[reg_wdata[`ALR_CFG_CAUX_HI:`ALR_CFG_CAUX_LO]] <= `ALR_SRC_COOL;
          end
        end
        `ALR_REG_EVT: begin
          evt_cancel <= reg_wdata[5:0];
        end
        `ALR_REG_SCUR: begin
          if (reg_wdata[9:0] <= `ALR_SCUR_MAX) begin
            short_cur <= reg_wdata[9:0];
          end
        end
        `ALR_REG_SHYS: begin
          // RULE7 range check
          if (reg_wdata[9:0] >= `ALR_SHYS_MIN && reg_wdata[9:0] <= `ALR_SCUR_MAX) begin
            short_hys <= reg_wdata[9:0];
          end
        end
        `ALR_REG_LBTIME: begin
          lb_time <= reg_wdata[13:0];
        end
        `ALR_REG_LBLEVEL: begin
          lb_level <= reg_wdata[13:0];
        end
        `ALR_REG_LBBAND: begin
          lb_band <= reg_wdata[13:0];
        end
        `ALR_REG_A1TYPE: begin
          a1_type <= reg_wdata[4:0];
        end
        `ALR_REG_COUT: begin
          // RULE15 refuse illegal source
          if (alr_allowed(reg_wdata[4:0], cfg[`ALR_CFG_RELAY1], 1'b0, cfg[`ALR_CFG_LOGIC])) begin
            cout_sel[0] <= reg_wdata[4:0];
          end
          if (alr_allowed(reg_wdata[12:8], cfg[`ALR_CFG_RELAY2], 1'b0, cfg[`ALR_CFG_LOGIC])) begin
            cout_sel[1] <= reg_wdata[12:8];
          end
        end
        `ALR_REG_AUX01: begin
          if (alr_allowed(reg_wdata[4:0], 1'b1, 1'b1, cfg[`ALR_CFG_LOGIC])) begin
            aux_sel[0] <= reg_wdata[4:0];
          end
          if (alr_allowed(reg_wdata[12:8], 1'b1, 1'b1, cfg[`ALR_CFG_LOGIC])) begin
            aux_sel[1] <= reg_wdata[12:8];
          end
        end
        `ALR_REG_AUX23: begin
          if (alr_allowed(reg_wdata[4:0], 1'b1, 1'b1, cfg[`ALR_CFG_LOGIC])) begin
            aux_sel[2] <= reg_wdata[4:0];
          end
          if (alr_allowed(reg_wdata[12:8], 1'b1, 1'b1, cfg[`ALR_CFG_LOGIC])) begin
            aux_sel[3] <= reg_wdata[12:8];
          end
        end
        `ALR_REG_LEVEL: begin
          level <= reg_wdata[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  // RULE13 control output routing
  // RULE18 auxiliary output routing
  always @(posedge clock) begin
    if (!rst_n) begin
      ctrl_out <= 2'b00;
      aux_out  <= 4'h0;
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        ctrl_out[i] <= alr_route(cout_sel[i], src);
      end
      for (i = 0; i < 4; i = i + 1) begin
        aux_out[i] <= alr_route(aux_sel[i], src);
      end
    end
  end

  // Register reads
  always @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      case (reg_addr)
        `ALR_REG_CFG:     reg_rdata <= cfg;
        `ALR_REG_EVT:     reg_rdata <= {10'h000, evt_cancel};
        `ALR_REG_SCUR:    reg_rdata <= {6'h00, short_cur};
        `ALR_REG_SHYS:    reg_rdata <= {6'h00, short_hys};
        `ALR_REG_LBTIME:  reg_rdata <= {2'b00, lb_time};
        `ALR_REG_LBLEVEL: reg_rdata <= {2'b00, lb_level};
        `ALR_REG_LBBAND:  reg_rdata <= {2'b00, lb_band};
        `ALR_REG_A1TYPE:  reg_rdata <= {11'h000, a1_type};
        `ALR_REG_COUT:    reg_rdata <= {3'b000, cout_sel[1], 3'b000, cout_sel[0]};
        `ALR_REG_AUX01:   reg_rdata <= {3'b000, aux_sel[1], 3'b000, aux_sel[0]};
        `ALR_REG_AUX23:   reg_rdata <= {3'b000, aux_sel[3], 3'b000, aux_sel[2]};
        `ALR_REG_LEVEL:   reg_rdata <= {13'h0000, level};
        `ALR_REG_STATUS:  reg_rdata <= {4'h0, aux_out, ctrl_out, 1'b0, cool_aux[1:0],
                                        lb_enable, loop_burnout, short_alarm};
        default:          reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule // alr_output_router

// file: verif/alr_router_props.sv
`timescale 1ns/10ps
module alr_router_props (
  input wire        clock,
  input wire        rst_n,
  input wire [3:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_write,
  input wire        reg_read,
  input wire [15:0] reg_rdata,
  input wire [9:0]  heater_current,
  input wire [5:0]  event_in,
  input wire        function_key,
  input wire        short_alarm,
  input wire        loop_burnout
);
  reg [15:0] cfg;
  reg [9:0]  scur;
  reg [4:0]  a1type;
  reg [2:0]  level;
  reg        lb_zero;
  reg [2:0]  quiet;
  // Shadow of written settings
  always @(posedge clock) begin
    if (!rst_n) begin
      cfg     <= 16'h038A;
      scur    <= 10'h032;
      a1type  <= 5'h00;
      level   <= 3'h0;
      lb_zero <= 1'b1;
      quiet   <= 3'h0;
    end else begin
      if (reg_write && reg_addr == 4'h0) cfg <= reg_wdata;
      if (reg_write && reg_addr == 4'h2 && reg_wdata[9:0] <= 10'h1F4) scur <= reg_wdata[9:0];
      if (reg_write && reg_addr == 4'h4) lb_zero <= (reg_wdata[13:0] == 14'h0000);
      if (reg_write && reg_addr == 4'h7) a1type <= reg_wdata[4:0];
      if (reg_write && reg_addr == 4'hB) level <= reg_wdata[2:0];
      if (function_key || event_in != 6'h00) quiet <= 3'h0;
      else if (quiet != 3'h7) quiet <= quiet + 3'h1;
    end
  end
  wire lvl_set = level >= 3'h1 && level <= 3'h4;
  wire lb_gate = cfg[3] && cfg[7] && a1type == 5'h0C;
  wire hold_ok = cfg[0] && cfg[1] && short_alarm && !reg_write && level == 3'h0 && scur != 10'h1F4 && quiet >= 3'h4;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_rdata_idle:
    assert property (!$past(reg_read) |-> reg_rdata == 16'h0000) else $error("read data outside read slot");
  chk_reset_clear:
    assert property (disable iff (1'b0) !rst_n |=> !short_alarm && !loop_burnout) else $error("reset left alarm set");
  chk_short_cause:
    assert property ($rose(short_alarm) |-> $past(heater_current) >= $past(scur) ||
      $past(heater_current, 2) >= $past(scur, 2)) else $error("short alarm without current");
  chk_level_off:
    assert property (lvl_set ##1 lvl_set |-> !short_alarm) else $error("short alarm in setting level");
  chk_latch_hold:
    assert property (hold_ok |=> short_alarm) else $error("latched short alarm dropped");
  chk_scur_release:
    assert property ((cfg[0] && scur == 10'h1F4 && heater_current < 10'h1F4) [*3] |-> !short_alarm)
      else $error("maximum current did not release");
  chk_lb_time_off:
    assert property ((lb_zero) [*3] |-> !loop_burnout) else $error("burnout flag with zero interval");
  chk_lb_gate_off:
    assert property ((!lb_gate) [*3] |-> !loop_burnout) else $error("burnout flag while not enabled");
  cover property ($rose(short_alarm));
  cover property ($fell(short_alarm) && cfg[0]);
  cover property ($rose(loop_burnout));
endmodule // alr_router_props

bind alr_output_router alr_router_props u_props (
  .clock, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .heater_current, .event_in, .function_key, .short_alarm, .loop_burnout
);

// file: verif/alr_drive_model.sv
`timescale 1ns/10ps
module alr_drive_model (
  input  wire       clock,
  output reg [5:0]  event_in,
  output reg        function_key,
  output reg [9:0]  heater_current
);
  initial begin
    event_in       = 6'h00;
    function_key   = 1'b0;
    heater_current = 10'h000;
  end
  // Measured heater current
  task set_current(input [9:0] value);
    @(posedge clock);
    heater_current <= value;
  endtask
  task pulse(input integer pin);
    @(posedge clock);
    if (pin < 6) event_in[pin] <= 1'b1;
    else function_key <= 1'b1;
    repeat (5) @(posedge clock);
    event_in     <= 6'h00;
    function_key <= 1'b0;
  endtask
endmodule // alr_drive_model

// file: verif/tb.sv
`timescale 1ns/10ps
module tb;
  reg         clock = 1'b0;
  reg         rst_n = 1'b0;
  reg  [3:0]  reg_addr = 4'h0;
  reg  [15:0] reg_wdata = 16'h0000;
  reg         reg_write = 1'b0;
  reg         reg_read = 1'b0;
  reg  [15:0] set_point = 16'h0000;
  reg  [15:0] process_value = 16'h0000;
  reg  [31:0] srcs = 32'h00000000;
  reg         heater_detect_fitted = 1'b1;
  wire        heat_ctrl = srcs[18];
  wire        cool_ctrl = srcs[19];
  wire [3:0]  alarm_in = srcs[3:0];
  wire        heater_burnout = srcs[4];
  wire        input_error = srcs[5];
  wire        remote_setpoint_fault = srcs[6];
  wire        program_end = srcs[7];
  wire        run_state = srcs[8];
  wire        integrated_alarm = srcs[9];
  wire [7:0]  work_bits = srcs[17:10];
  wire [15:0] reg_rdata;
  wire [5:0]  event_in;
  wire        function_key;
  wire [9:0]  heater_current;
  wire [1:0]  ctrl_out;
  wire [3:0]  aux_out;
  wire        short_alarm;
  wire        loop_burnout;
  integer     num_errors = 0;
  integer     compares = 0;
  integer     cycles = 0;
  integer     seed = 81827;
  integer     i;
  always #10 clock = ~clock;
  alr_drive_model u_model (.clock(clock), .event_in(event_in), .function_key(function_key),
    .heater_current(heater_current));
  alr_output_router #(.TICKS_PER_UNIT(4)) u_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .heater_detect_fitted(heater_detect_fitted), .heater_current(heater_current), .event_in(event_in),
    .function_key(function_key), .set_point(set_point), .process_value(process_value),
    .heat_ctrl(heat_ctrl), .cool_ctrl(cool_ctrl), .alarm_in(alarm_in), .heater_burnout(heater_burnout),
    .input_error(input_error), .remote_setpoint_fault(remote_setpoint_fault), .program_end(program_end),
    .run_state(run_state), .integrated_alarm(integrated_alarm), .work_bits(work_bits), .ctrl_out(ctrl_out),
    .aux_out(aux_out),
    .short_alarm(short_alarm), .loop_burnout(loop_burnout));
  // Source model, current kept low so short alarm is 0
  function expect_src(input [4:0] code);
    begin
      if (code >= 5'h03 && code <= 5'h06) expect_src = srcs[code - 5'h03];
      else if (code >= 5'h0F && code <= 5'h16) expect_src = srcs[code - 5'h05];
      else case (code)
        5'h01: expect_src = srcs[18];
        5'h07, 5'h08: expect_src = srcs[4];
        5'h0A: expect_src = srcs[5];
        5'h0B: expect_src = srcs[6];
        5'h0D: expect_src = srcs[8];
        5'h0E: expect_src = srcs[9];
        default: expect_src = 1'b0;
      endcase
    end
  endfunction
  task test_done;
    if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string name, input [15:0] seen, input [15:0] want);
    compares = compares + 1;
    if (seen !== want) begin
      num_errors = num_errors + 1;
      $display("wrong value %s expected %h seen %h", name, want, seen);
    end
  endtask
  task wr(input [3:0] a, input [15:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task rd(input [3:0] a, input [15:0] want);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, want);
  endtask
  task settle(input integer n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      test_done;
    end
  end
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    rd(4'h0, 16'h038A);
    rd(4'h2, 16'h0032);
    rd(4'h3, 16'h0001);
    rd(4'h5, 16'h0050);
    rd(4'h6, 16'h001E);
    rd(4'h8, 16'h0001);
    rd(4'h9, 16'h0407);
    rd(4'hA, 16'h0605);
    rd(4'hD, 16'h0000);
    wr(4'h0, 16'h138B);
    wr(4'h1, 16'h0004);
    for (i = 0; i < 4; i = i + 1) begin
      u_model.set_current(10'h03C);
      settle(4);
      chk("short_alarm", {15'h0, short_alarm}, 16'h0001);
      u_model.set_current(10'h000);
      settle(4);
      chk("short_alarm", {15'h0, short_alarm}, 16'h0001);
      case (i)
        0: u_model.pulse(2);
        1: u_model.pulse(6);
        2: wr(4'h2, 16'h01F4);
        default: wr(4'hB, 16'h0001);
      endcase
      settle(4);
      chk("short_alarm", {15'h0, short_alarm}, 16'h0000);
      wr(4'h2, 16'h0032);
      wr(4'hB, 16'h0000);
    end
    wr(4'h0, 16'h038A);
    wr(4'h3, 16'h000A);
    u_model.set_current(10'h03C);
    settle(4);
    chk("short_alarm", {15'h0, short_alarm}, 16'h0001);
    u_model.set_current(10'h02D);
    settle(4);
    chk("short_alarm", {15'h0, short_alarm}, 16'h0001);
    u_model.set_current(10'h027);
    settle(4);
    chk("short_alarm", {15'h0, short_alarm}, 16'h0000);
    u_model.set_current(10'h000);
    wr(4'h2, 16'h01F5);
    rd(4'h2, 16'h0032);
    wr(4'h3, 16'h0000);
    rd(4'h3, 16'h000A);
    wr(4'h0, 16'h039A);
    for (i = 0; i < 23; i = i + 1) begin
      wr(4'h8, i[15:0]);
      wr(4'h9, 16'h0400 | i[15:0]);
      @(posedge clock);
      srcs <= $random(seed);
      settle(2);
      chk("ctrl_out", {15'h0, ctrl_out[0]}, {15'h0, expect_src(i[4:0])});
      chk("aux_out", {15'h0, aux_out[0]}, {15'h0, expect_src(i[4:0])});
    end
    wr(4'h0, 16'h028A);
    wr(4'h8, 16'h0003);
    rd(4'h8, 16'h0016);
    wr(4'h9, 16'h040F);
    rd(4'h9, 16'h0416);
    wr(4'h0, 16'h038E);
    rd(4'h8, 16'h0216);
    settle(2);
    chk("ctrl_out", {15'h0, ctrl_out[1]}, {15'h0, srcs[19]});
    wr(4'h0, 16'h038A);
    wr(4'h0, 16'h07CE);
    rd(4'h9, 16'h0216);
    wr(4'h0, 16'h038A);
    @(posedge clock);
    set_point <= 16'h03E8;
    wr(4'h7, 16'h000C);
    wr(4'h4, 16'h0001);
    settle(40);
    chk("loop_burnout", {15'h0, loop_burnout}, 16'h0001);
    @(posedge clock);
    process_value <= 16'h0384;
    for (i = 0; i < 8 && loop_burnout; i = i + 1) settle(1);
    chk("loop_burnout", {15'h0, loop_burnout}, 16'h0000);
    wr(4'h4, 16'h0000);
    settle(4);
    chk("loop_burnout", {15'h0, loop_burnout}, 16'h0000);
    wr(4'h4, 16'h0001);
    wr(4'h7, 16'h0000);
    settle(40);
    chk("loop_burnout", {15'h0, loop_burnout}, 16'h0000);
    wr(4'h0, 16'h038B);
    u_model.set_current(10'h03C);
    settle(4);
    u_model.set_current(10'h000);
    @(posedge clock);
    rst_n                <= 1'b0;
    heater_detect_fitted <= 1'b0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    chk("short_alarm", {15'h0, short_alarm}, 16'h0000);
    rd(4'h9, 16'h0403);
    test_done;
  end
endmodule // tb
